// ===== design/exec_consts.svh
// Purpose: Constants for the OR and move instruction execute block
// Assumes: 16-bit instruction words, 12-bit data addresses, APB register map
// Notes: Summary follows
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define OFS_CONTROL 12'h000
`define OFS_STATE 12'h004
`define OFS_POINTER0 12'h008
`define OFS_POINTER1 12'h00c
`define OFS_POINTER2 12'h010
`define CTRL_EXT_BIT 0
`define CTRL_RESET 32'h0000_0000
`define ACC_RESET 8'h00
`define BANK_RESET 8'h00
`define ILO_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h60
`define ACC_FILE_ADDR 12'hfe8
`define PHASE_COUNT 4
`endif

// ===== design/exec_pkg.sv
// Purpose: Types shared by the execute block
// Assumes: Nothing beyond the constants header
// Notes: Memory request travels as one packed struct
`default_nettype none
package exec_pkg;
	typedef enum logic [1:0] {
		phase_decode,
		phase_read,
		phase_process,
		phase_write
	} phase_type;
	typedef enum logic [1:0] {
		pend_none,
		pend_pointer,
		pend_move
	} pend_type;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
	} mem_req_type;
endpackage
`default_nettype wire

// ===== design/or_and_move_instruction_exec.sv
// Purpose: Execute OR, move, pointer load and bank load instructions
// Assumes: Data memory reads combinationally in the cycle rd is high
// Notes: Registers reached over APB, zero wait states
//
// The address map and the APB slave port were decided locally.
`include "exec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module or_and_move_instruction_exec import exec_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	output logic instr_ack,
	output mem_req_type mem_req,
	input wire logic [7:0] mem_rdata
);
	function automatic logic [1:0] nz_of(input logic [7:0] r);
		return {r[7], r == 8'h00};
	endfunction

	function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
		input logic [7:0] bank, input logic ext, input logic [11:0] base);
		if (a)
			return {bank[3:0], f};
		if (ext && f <= `ILO_LIMIT)
			return 12'(base + {4'h0, f});
		if (f < `ACCESS_SPLIT)
			return {4'h0, f};
		return {4'hf, f};
	endfunction

	phase_type phase;
	pend_type pend;
	logic [15:0] ir;
	logic ir_ok;
	logic [7:0] acc;
	logic [7:0] bank;
	logic neg;
	logic zero;
	logic ext_en;
	logic [11:0] pointer [0:2];
	logic [1:0] ptr_sel;
	logic [7:0] opnd;
	// Reset value of the control word, held as a vector so one bit can be picked
	localparam logic [31:0] ctrl_reset = `CTRL_RESET;

	// Decode, gated so a second word never aliases a first-word opcode
	wire logic second = (pend != pend_none);
	wire logic first = ir_ok && !second;
	wire logic is_orl = first && ir[15:8] == 8'h09;
	wire logic is_orf = first && ir[15:10] == 6'b000100;
	wire logic is_move_file_to_dest = first && ir[15:10] == 6'b010100;
	wire logic is_load_acc_literal = first && ir[15:8] == 8'h0e;
	wire logic is_load_bank_literal = first && ir[15:8] == 8'h01;
	wire logic is_store_acc_to_file = first && ir[15:9] == 7'b0110111;
	wire logic is_load_pointer_literal = first && ir[15:6] == 10'b1110111000 && ir[5:4] != 2'b11;
	wire logic is_move_file_to_file = first && ir[15:12] == 4'hc;
	wire logic is_ptr2 = ir_ok && pend == pend_pointer;
	wire logic is_move2 = ir_ok && pend == pend_move;
	wire logic dir_file = ir[9];
	wire logic [11:0] bank_addr = file_addr(ir[7:0], ir[8], bank, ext_en, pointer[2]);
	wire logic [11:0] src_addr = is_move_file_to_file ? ir[11:0] : bank_addr;
	wire logic needs_read = is_orf || is_move_file_to_dest || is_move_file_to_file;
	wire logic [7:0] or_file = acc | opnd;
	wire logic [7:0] or_lit = acc | ir[7:0];
	wire logic [7:0] src_val = (is_move_file_to_file && ir[11:0] == `ACC_FILE_ADDR) ? acc : mem_rdata;

	// Instruction word taken at the end of the write phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= phase_decode;
			ir <= 16'h0000;
			ir_ok <= 1'b0;
			instr_ack <= 1'b0;
		end else begin
			instr_ack <= 1'b0;
			case (phase)
				phase_decode: phase <= phase_read;
				phase_read: phase <= phase_process;
				phase_process: phase <= phase_write;
				phase_write: begin
					phase <= phase_decode;
					ir <= instr_word;
					ir_ok <= instr_valid;
					instr_ack <= instr_valid;
				end
				default: phase <= phase_decode;
			endcase
		end
	end

	// Memory request: read during read phase, write during write phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= '0;
		end else begin
			mem_req.rd <= 1'b0;
			mem_req.wr <= 1'b0;
			if (phase == phase_decode && needs_read) begin
				mem_req.addr <= src_addr;
				mem_req.rd <= !(is_move_file_to_file && ir[11:0] == `ACC_FILE_ADDR);
			end
			if (phase == phase_process) begin
				if ((is_orf || is_move_file_to_dest) && dir_file) begin
					mem_req.addr <= bank_addr;
					mem_req.wdata <= is_orf ? or_file : opnd;
					mem_req.wr <= 1'b1;
				end
				if (is_store_acc_to_file) begin
					mem_req.addr <= bank_addr;
					mem_req.wdata <= acc;
					mem_req.wr <= 1'b1;
				end
				// Second move word writes without a dummy read
				if (is_move2 && ir[11:0] != `ACC_FILE_ADDR) begin
					mem_req.addr <= ir[11:0];
					mem_req.wdata <= opnd;
					mem_req.wr <= 1'b1;
				end
			end
		end
	end

	// Operand capture; held across both move cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			opnd <= 8'h00;
		else if (phase == phase_read && needs_read)
			opnd <= src_val;
	end

	// Next values of the core state, settled before the process edge
	wire logic at_process = (phase == phase_process);
	wire logic upd_nz = is_orl || is_orf || is_move_file_to_dest;
	wire logic [7:0] nz_src = is_orl ? or_lit : is_orf ? or_file : opnd;
	wire logic [1:0] next_nz = nz_of(nz_src);
	wire logic acc_move2 = is_move2 && ir[11:0] == `ACC_FILE_ADDR;
	wire logic [7:0] next_acc =
		is_orl ? or_lit :
		(is_orf && !dir_file) ? or_file :
		(is_move_file_to_dest && !dir_file) ? opnd :
		is_load_acc_literal ? ir[7:0] :
		acc_move2 ? opnd : acc;
	// Upper nibble of the bank select never takes the literal's top bits
	wire logic [7:0] next_bank = is_load_bank_literal ? {4'h0, ir[3:0]} : bank;
	pend_type next_pend;
	always_comb begin
		next_pend = pend;
		if (is_load_pointer_literal)
			next_pend = pend_pointer;
		else if (is_move_file_to_file)
			next_pend = pend_move;
		else if (is_ptr2 || is_move2)
			next_pend = pend_none;
	end

	// Core state updated at the end of processing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= `ACC_RESET;
			bank <= `BANK_RESET;
			pend <= pend_none;
		end else if (at_process) begin
			acc <= next_acc;
			bank <= next_bank;
			pend <= next_pend;
		end
	end

	// Flags move only for the three instructions that report them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			{neg, zero} <= 2'b00;
		else if (at_process && upd_nz)
			{neg, zero} <= next_nz;
	end

	// Pointer halves land in separate instruction cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_sel <= 2'd0;
			pointer[0] <= 12'h000;
			pointer[1] <= 12'h000;
			pointer[2] <= 12'h000;
		end else if (at_process) begin
			if (is_load_pointer_literal) begin
				pointer[ir[5:4]][11:8] <= ir[3:0];
				ptr_sel <= ir[5:4];
			end
			if (is_ptr2)
				pointer[ptr_sel][7:0] <= ir[7:0];
		end
	end

	// APB slave: answer in the first access cycle
	wire logic setup = psel && !penable;
	wire logic wr_take = psel && penable && pready && pwrite;
	wire logic hit_ctrl = paddr == `OFS_CONTROL;
	wire logic hit_state = paddr == `OFS_STATE;
	wire logic hit_p0 = paddr == `OFS_POINTER0;
	wire logic hit_p1 = paddr == `OFS_POINTER1;
	wire logic hit_p2 = paddr == `OFS_POINTER2;
	wire logic mapped = hit_ctrl || hit_state || hit_p0 || hit_p1 || hit_p2;
	wire logic [31:0] state_word = {13'h0000, second, neg, zero, bank, acc};
	wire logic [31:0] read_word =
		hit_ctrl ? {31'h0000_0000, ext_en} :
		hit_state ? state_word :
		hit_p0 ? {20'h00000, pointer[0]} :
		hit_p1 ? {20'h00000, pointer[1]} :
		hit_p2 ? {20'h00000, pointer[2]} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup)
				prdata <= pwrite ? 32'h0000_0000 : read_word;
		end
	end

	// Only the control register is writable; state words are read only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_en <= ctrl_reset[`CTRL_EXT_BIT];
		else if (wr_take && hit_ctrl)
			ext_en <= pwdata[`CTRL_EXT_BIT];
	end
endmodule
`default_nettype wire

// ===== tb/exec_asserts.sv
// Purpose: Port timing checks for the execute block
// Assumes: Zero-wait APB slave
// Notes: Bound into the design top
`timescale 1ns/1ps
`default_nettype none
module exec_asserts import exec_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic instr_valid,
	input wire logic instr_ack,
	input wire mem_req_type mem_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ack_spacing: assert property (instr_ack |=> !instr_ack [*3]) else $error("ack spacing");
	a_ack_cause: assert property (instr_ack |-> $past(instr_valid)) else $error("ack cause");
	a_rd_phase: assert property (mem_req.rd |-> $past(instr_ack)) else $error("rd phase");
	a_wr_phase: assert property (mem_req.wr |-> $past(instr_ack, 3)) else $error("wr phase");
	a_rw_apart: assert property (!(mem_req.rd && mem_req.wr)) else $error("rd with wr");
	a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind or_and_move_instruction_exec exec_asserts i_exec_asserts (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.instr_valid(instr_valid),
	.instr_ack(instr_ack),
	.mem_req(mem_req)
);
`default_nettype wire

// ===== tb/data_mem_model.sv
// Purpose: Data memory beside the execute block
// Assumes: Read is combinational while rd is high
// Notes: Bench preloads the array
`timescale 1ns/1ps
`default_nettype none
module data_mem_model import exec_pkg::*; (
	input wire logic pclk,
	input wire mem_req_type mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [4096];
	// Inverted when not read, so stale data never matches by luck
	assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~mem[mem_req.addr];
	always @(posedge pclk) if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
endmodule
`default_nettype wire

// ===== tb/or_and_move_instruction_exec_tb_top.sv
// Purpose: Random self-checking bench for the execute block
// Assumes: Zero-wait APB, memory model answers at once
// Notes: Expected state kept in bench variables
`timescale 1ns/1ps
`default_nettype none
module or_and_move_instruction_exec_tb_top import exec_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
	logic [11:0] paddr = 0, ad, dst;
	logic [31:0] pwdata = 0, prdata, r, rd;
	logic [15:0] instr_word = 0, w, w2;
	logic pready, pslverr, instr_ack, er, ext, n, z, fl, wa, wf, tw;
	logic [7:0] mem_rdata, acc, bank, res, f, em [4096];
	logic [11:0] ptr [3];
	mem_req_type mem_req;
	int seed = 56585, num_errors = 0, checked = 0, k, e, s;
	always #4 pclk = ~pclk;
	or_and_move_instruction_exec i_or_and_move_instruction_exec (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.instr_word(instr_word),
		.instr_valid(instr_valid),
		.instr_ack(instr_ack),
		.mem_req(mem_req),
		.mem_rdata(mem_rdata)
	);
	data_mem_model i_data_mem_model (
		.pclk(pclk),
		.mem_req(mem_req),
		.mem_rdata(mem_rdata)
	);
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1 && i < 50);
		if (i == 50) num_errors++;
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 0;
	endtask
	task exec(input logic [15:0] word);
		int i;
		{instr_word, instr_valid} <= {word, 1'b1};
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (instr_ack !== 1 && i < 20);
		if (i == 20) num_errors++;
	endtask
	task chk;
		repeat (4) @(posedge pclk);
		apb(0, 12'h004, 0);
		cmp(rd, {14'h0, n, z, bank, acc});
		cmp(i_data_mem_model.mem[dst], em[dst]);
	endtask
	function automatic logic [11:0] ea(input logic [7:0] x, input logic a);
		if (a) return {bank[3:0], x};
		if (ext && x <= 8'h5f) return ptr[2] + x;
		return {x < 8'h60 ? 4'h0 : 4'hf, x};
	endfunction
	initial begin
		#200000;
		num_errors++;
		print_verdict;
	end
	initial begin
		for (k = 0; k < 4096; k++) begin
			em[k] = 8'($random(seed));
			i_data_mem_model.mem[k] = em[k];
		end
		{acc, bank, n, z, ext, dst} = 0;
		ptr = '{0, 0, 0};
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0);
		cmp(rd, 0);
		apb(1, 12'h004, '1);
		chk;
		for (e = 0; e < 2; e++) begin
			for (k = 0; k < 60; k++) begin
				r = $random(seed);
				f = r[7:0];
				ad = ea(f, r[9]);
				{tw, fl, wa, wf} = 0;
				case (r[30:28])
				0: {w, fl, wa, wf, res} = {8'h09, f, 3'b110, acc | f};
				1: {w, fl, wa, wf, res} = {6'h04, r[8], r[9], f, 1'b1, !r[8], r[8], acc | em[ad]};
				2: {w, fl, wa, wf, res} = {6'h14, r[8], r[9], f, 1'b1, !r[8], r[8], em[ad]};
				3: {w, fl, wa, wf, res} = {7'h37, r[9], f, 3'b001, acc};
				4: {w, fl, wa, wf, res} = {8'h0e, f, 3'b010, f};
				5: {w, bank} = {8'h01, f, 4'h0, f[3:0]};
				6: begin
					s = r[17:16] % 3;
					{tw, w, w2} = {1'b1, 10'h3b8, 2'(s), r[27:24], 8'hf0, f};
					ptr[s] = {r[27:24], f};
				end
				default: begin
					ad = r[24] ? 12'hfe8 : r[11:0];
					dst = r[25] ? 12'hfe8 : r[23:12];
					if (dst == 12'hff9 || dst >= 12'hffd) dst = 12'hfe8;
					{tw, w, w2, res} = {1'b1, 4'hc, ad, 4'hf, dst, ad == 12'hfe8 ? acc : em[ad]};
					{wa, wf, ad} = {dst == 12'hfe8, dst != 12'hfe8, dst};
				end
				endcase
				exec(w);
				if (tw) exec(w2);
				instr_valid <= 0;
				if (fl) {n, z} = {res[7], res == 8'h00};
				if (wa) acc = res;
				if (wf) {em[ad], dst} = {res, ad};
				chk;
			end
			// Second pass runs with indexed offset addressing on
			apb(1, 12'h000, 1);
			ext = 1;
		end
		for (k = 0; k < 3; k++) begin
			apb(0, 12'(8 + 4 * k), 0);
			cmp(rd, {20'h0, ptr[k]});
		end
		apb(0, 12'h020, 0);
		cmp(er, 1);
		cmp(rd, 0);
		print_verdict;
	end
endmodule
`default_nettype wire
